// ==== src/ciu_cfg.svh ====
// Register map, field positions, reset values and cycle counts of the unit
`ifndef CIU_CFG_SVH
`define CIU_CFG_SVH

`define CIU_OFF_CTRL   8'h00
`define CIU_OFF_STAT   8'h04
`define CIU_OFF_ACC    8'h08
`define CIU_OFF_OPND   8'h0C
`define CIU_OFF_FLAGS  8'h10
`define CIU_OFF_ADJ    8'h14
`define CIU_OFF_CYC    8'h18

`define CIU_CTRL_OP_HI   3
`define CIU_CTRL_OP_LO   0
`define CIU_CTRL_FM_HI   5
`define CIU_CTRL_FM_LO   4
`define CIU_CTRL_START   8
`define CIU_STAT_BUSY    0
`define CIU_STAT_LOCK    1
`define CIU_OP_LAST      4'hC

`define CIU_FLAG_N  3
`define CIU_FLAG_Z  2
`define CIU_FLAG_V  1
`define CIU_FLAG_C  0

`define CIU_RST_WORD   32'h0000_0000
`define CIU_RST_FLAGS  4'h0
`define CIU_RST_ADJ    8'h00
`define CIU_RST_CYC    9'h000
`define CIU_ONE        32'h0000_0001
`define CIU_SH_BYTE    24
`define CIU_SH_WORD    16

`define CIU_CY_INCB    9'h002
`define CIU_CY_DECB    9'h003
`define CIU_CY_IDW     9'h003
`define CIU_CY_IDBW_M  9'h005
`define CIU_CY_IDL     9'h007
`define CIU_CY_IDL_M   9'h009
`define CIU_CY_CMP_A   9'h001
`define CIU_CY_CMP_R   9'h002
`define CIU_CY_CMP_M   9'h003
`define CIU_CY_COMPARE_LONG_I  9'h003
`define CIU_CY_COMPARE_LONG_R  9'h006
`define CIU_CY_COMPARE_LONG_M  9'h007
`define CIU_CY_DVB_A   {9'h003, 9'h007, 9'h00F}
`define CIU_CY_DVB_R   {9'h004, 9'h008, 9'h010}
`define CIU_CY_DVB_M   {9'h006, 9'h009, 9'h013}
`define CIU_CY_DVW_R   {9'h004, 9'h007, 9'h016}
`define CIU_CY_DVW_M   {9'h006, 9'h008, 9'h01A}
`define CIU_CY_MLB_A   {9'h003, 9'h000, 9'h007}
`define CIU_CY_MLB_R   {9'h004, 9'h000, 9'h008}
`define CIU_CY_MLB_M   {9'h005, 9'h000, 9'h009}
`define CIU_CY_MLW_A   {9'h003, 9'h000, 9'h00B}
`define CIU_CY_MLW_R   {9'h004, 9'h000, 9'h00C}
`define CIU_CY_MLW_M   {9'h005, 9'h000, 9'h00D}

`endif

// ==== src/ciu_pkg.sv ====
// Types shared by the arithmetic unit
package ciu_pkg;
  typedef enum logic [3:0] {
    OP_ADD_ONE_BYTE           = 4'h0,
    OP_SUBTRACT_ONE_BYTE      = 4'h1,
    OP_ADD_ONE_WORD           = 4'h2,
    OP_SUBTRACT_ONE_WORD      = 4'h3,
    OP_ADD_ONE_LONG           = 4'h4,
    OP_SUBTRACT_ONE_LONG      = 4'h5,
    OP_COMPARE_BYTE           = 4'h6,
    OP_COMPARE_WORD           = 4'h7,
    OP_COMPARE_LONG           = 4'h8,
    OP_UNSIGNED_QUOTIENT_BYTE = 4'h9,
    OP_UNSIGNED_QUOTIENT_WORD = 4'hA,
    OP_UNSIGNED_PRODUCT_BYTE  = 4'hB,
    OP_UNSIGNED_PRODUCT_WORD  = 4'hC
  } ciu_op_t;
  typedef enum logic [1:0] {
    FORM_ACC = 2'h0, FORM_REG = 2'h1, FORM_MEM = 2'h2, FORM_RSV = 2'h3
  } ciu_form_t;
  typedef enum logic [1:0] {
    CASE_ZERO = 2'h2, CASE_OVF = 2'h1, CASE_NORMAL = 2'h0
  } ciu_case_t;
  typedef enum logic [1:0] {
    W_BYTE = 2'h0, W_WORD = 2'h1, W_LONG = 2'h2
  } ciu_width_t;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01, ST_RUN = 2'b10
  } ciu_state_t;
endpackage

// ==== src/ciu_muldiv.sv ====
// Unsigned multiply and divide results with early-exit case detection
`timescale 1ns/1ps
module ciu_muldiv (
  // Operation
  input  ciu_pkg::ciu_op_t   i_op,
  input  ciu_pkg::ciu_form_t i_form,
  // Operands
  input  wire logic [31:0]   i_acc,
  input  wire logic [31:0]   i_opnd,
  // Results
  output logic      [31:0]   o_acc,
  output logic      [31:0]   o_opnd,
  output ciu_pkg::ciu_case_t o_case
);
  import ciu_pkg::*;

  logic [31:0] dvd;
  logic [31:0] dvs;
  logic [31:0] quo;
  logic [31:0] rem;
  logic        acc_form;

  always_comb begin
    acc_form = (i_form == FORM_ACC);
    o_acc    = i_acc;
    o_opnd   = i_opnd;
    o_case   = CASE_NORMAL;
    dvd      = 32'h0000_0000;
    dvs      = 32'h0000_0000;
    case (i_op)
      OP_UNSIGNED_PRODUCT_BYTE: begin
        dvd = {24'h00_0000, acc_form ? i_acc[23:16] : i_opnd[7:0]};
        if (dvd == 32'h0000_0000) o_case = CASE_ZERO;
        o_acc[15:0] = dvd[15:0] * {8'h00, i_acc[7:0]};
      end
      OP_UNSIGNED_PRODUCT_WORD: begin
        dvd = {16'h0000, acc_form ? i_acc[31:16] : i_opnd[15:0]};
        if (dvd == 32'h0000_0000) o_case = CASE_ZERO;
        o_acc = dvd * {16'h0000, i_acc[15:0]};
      end
      OP_UNSIGNED_QUOTIENT_BYTE: begin
        dvd = {16'h0000, acc_form ? i_acc[31:16] : i_acc[15:0]};
        dvs = {24'h00_0000, acc_form ? i_acc[7:0] : i_opnd[7:0]};
      end
      OP_UNSIGNED_QUOTIENT_WORD: begin
        dvd = i_acc;
        dvs = {16'h0000, i_opnd[15:0]};
      end
      default: begin
        dvd = 32'h0000_0000;
      end
    endcase
    quo = (dvs == 32'h0000_0000) ? 32'h0000_0000 : dvd / dvs;
    rem = (dvs == 32'h0000_0000) ? 32'h0000_0000 : dvd % dvs;
    if (i_op == OP_UNSIGNED_QUOTIENT_BYTE) begin
      if (dvs == 32'h0000_0000 || quo[31:8] != 24'h00_0000) begin
        o_case = CASE_OVF;
      end else begin
        if (quo == 32'h0000_0000) o_case = CASE_ZERO;
        o_acc[7:0] = quo[7:0];
        if (acc_form) o_acc[23:16] = rem[7:0];
        else o_opnd[7:0] = rem[7:0];
      end
    end
    if (i_op == OP_UNSIGNED_QUOTIENT_WORD) begin
      if (dvs == 32'h0000_0000 || quo[31:16] != 16'h0000) begin
        o_case = CASE_OVF;
      end else begin
        if (quo == 32'h0000_0000) o_case = CASE_ZERO;
        o_acc[15:0]  = quo[15:0];
        o_opnd[15:0] = rem[15:0];
      end
    end
  end
endmodule

// ==== src/ciu_timer.sv ====
// Down counter that marks the last cycle of an operation
`timescale 1ns/1ps
module ciu_timer (
  // Clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_rst_n,
  // Load
  input  wire logic       i_load,
  input  wire logic [8:0] i_count,
  // Status
  output logic            o_last
);
  logic [8:0] cnt;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt <= 9'h000;
    end else if (i_load) begin
      cnt <= i_count;
    end else if (cnt != 9'h000) begin
      cnt <= cnt - 9'h001;
    end
  end

  assign o_last = (cnt == 9'h001);
endmodule

// ==== src/ciu_top.sv ====
// Increment, compare, multiply and divide unit with APB register access
//
// What this block does
// - Increment and decrement set N, Z, V from the result; carry kept.
// - Byte add-one writes operand plus one back, taking 2 cycles, or 5 plus correction in memory form.
// - Word add-one writes 16-bit operand plus one back in 3 cycles, or 5 plus correction in memory form.
// - Long add-one adds one to 32-bit operand in place, 7 cycles, or 9 plus correction in memory form.
// - Long subtract-one: 7 cycles register form, 9 plus correction memory.
// - Compares subtract second from first, set N Z V C, change no register.
// - Byte product of upper by lower accumulator byte in accumulator form, else operand low byte by lower byte; flags unchanged.
// - Word product of upper by lower accumulator word in accumulator form, else operand low word by lower word; flags unchanged.
// - Byte quotient to low byte, remainder to high byte in accumulator form, else to operand low byte; only V, C.
// - Word quotient into accumulator, word remainder into register operand.
// - Accumulator byte divide takes 3 zero, 7 overflow, 15 otherwise.
// - Register byte divide takes 4 zero, 8 overflow, 16 otherwise.
// - Memory byte divide takes 6, 9 or 19 plus correction.
// - Word divide 4, 7, 22 register; 6, 8, 26 plus correction memory.
// - Accumulator byte multiply takes 3 if upper byte zero, else 7.
// - Register byte multiply 4 or 8; memory form 5 or 9 plus correction.
// - Accumulator word multiply takes 3 if upper word zero, else 11.
// - Register word multiply 4 or 12; memory form 5 or 13 plus correction.
`timescale 1ns/1ps
`include "ciu_cfg.svh"
module ciu_top (
  // Clock and reset
  input  wire logic        I_SYS_CLK,
  input  wire logic        I_RSTN,
  // APB slave
  input  wire logic        I_PSEL,
  input  wire logic        I_PENABLE,
  input  wire logic        I_PWRITE,
  input  wire logic [7:0]  I_PADDR,
  input  wire logic [31:0] I_PWDATA,
  output logic      [31:0] O_PRDATA,
  output logic             O_PREADY,
  output logic             O_PSLVERR,
  // Status
  output logic             O_BUSY,
  output logic             O_BUS_LOCK,
  output logic      [3:0]  O_FLAGS
);
  import ciu_pkg::*;

  logic        rst_meta;
  logic        rst_n;
  ciu_state_t  state;
  ciu_op_t     op;
  ciu_form_t   form;
  ciu_op_t     new_op;
  ciu_form_t   new_form;
  logic [31:0] acc;
  logic [31:0] opnd;
  logic [3:0]  flags;
  logic [7:0]  adj;
  logic [8:0]  cyc;
  logic [31:0] pend_acc;
  logic [31:0] pend_opnd;
  logic [3:0]  pend_flags;
  logic [31:0] md_acc;
  logic [31:0] md_opnd;
  ciu_case_t   md_case;
  logic        access;
  logic        wr_ok;
  logic        start;
  logic        tmr_last;
  logic        busy;
  logic [31:0] next_rdata;
  logic        next_err;
  logic [31:0] next_acc;
  logic [31:0] next_opnd;
  logic [3:0]  next_flags;
  logic [8:0]  next_cyc;

  // Reset release through two flops
  always_ff @(posedge I_SYS_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  function automatic logic [5:0] shift_of(ciu_width_t w);
    case (w)
      W_BYTE:  shift_of = 6'(`CIU_SH_BYTE);
      W_WORD:  shift_of = 6'(`CIU_SH_WORD);
      default: shift_of = 6'h00;
    endcase
  endfunction

  // Puts the operand's top bit at bit 31 so one adder serves all widths
  function automatic logic [31:0] align(ciu_width_t w, logic [31:0] x);
    align = x << shift_of(w);
  endfunction

  function automatic ciu_width_t width_of(ciu_op_t o);
    case (o)
      OP_ADD_ONE_BYTE, OP_SUBTRACT_ONE_BYTE, OP_COMPARE_BYTE:
        width_of = W_BYTE;
      OP_ADD_ONE_WORD, OP_SUBTRACT_ONE_WORD, OP_COMPARE_WORD:
        width_of = W_WORD;
      default: width_of = W_LONG;
    endcase
  endfunction

  // Add or subtract one at the operand width, upper bits kept
  function automatic logic [35:0] step_fn(ciu_op_t o, logic [31:0] v,
                                          logic [3:0] f);
    ciu_width_t  w;
    logic        inc;
    logic [31:0] as;
    logic [31:0] rs;
    logic [31:0] keep;
    logic [3:0]  nf;
    w    = width_of(o);
    inc  = (o == OP_ADD_ONE_BYTE) || (o == OP_ADD_ONE_WORD) ||
           (o == OP_ADD_ONE_LONG);
    as   = align(w, v);
    rs   = inc ? as + align(w, `CIU_ONE) : as - align(w, `CIU_ONE);
    keep = ~(32'hFFFF_FFFF >> shift_of(w));
    nf   = f;
    nf[`CIU_FLAG_N] = rs[31];
    nf[`CIU_FLAG_Z] = (rs == 32'h0000_0000);
    nf[`CIU_FLAG_V] = inc ? (!as[31] && rs[31]) : (as[31] && !rs[31]);
    step_fn = {nf, (v & keep) | (rs >> shift_of(w))};
  endfunction

  // Flags of a minus b at the given width
  function automatic logic [3:0] cmp_fn(ciu_width_t w, logic [31:0] a,
                                        logic [31:0] b);
    logic [31:0] as;
    logic [31:0] bs;
    logic [32:0] d;
    logic [3:0]  nf;
    as = align(w, a);
    bs = align(w, b);
    d  = {1'b0, as} - {1'b0, bs};
    nf[`CIU_FLAG_N] = d[31];
    nf[`CIU_FLAG_Z] = (d[31:0] == 32'h0000_0000);
    nf[`CIU_FLAG_V] = (as[31] ^ bs[31]) & (as[31] ^ d[31]);
    nf[`CIU_FLAG_C] = d[32];
    cmp_fn = nf;
  endfunction

  // Chooses among zero, overflow and normal counts packed high to low
  function automatic logic [8:0] pick(ciu_case_t c, logic [26:0] t);
    case (c)
      CASE_ZERO: pick = t[26:18];
      CASE_OVF:  pick = t[17:9];
      default:   pick = t[8:0];
    endcase
  endfunction

  // Cycle count of an operation; memory forms add the addressing correction
  function automatic logic [8:0] cyc_fn(ciu_op_t o, ciu_form_t fm,
                                        ciu_case_t c, logic [7:0] a);
    logic       mem;
    logic       af;
    logic [8:0] base;
    mem = (fm == FORM_MEM);
    af  = (fm == FORM_ACC);
    case (o)
      OP_ADD_ONE_BYTE:
        base = mem ? `CIU_CY_IDBW_M : `CIU_CY_INCB;
      OP_SUBTRACT_ONE_BYTE:
        base = mem ? `CIU_CY_IDBW_M : `CIU_CY_DECB;
      OP_ADD_ONE_WORD, OP_SUBTRACT_ONE_WORD:
        base = mem ? `CIU_CY_IDBW_M : `CIU_CY_IDW;
      OP_ADD_ONE_LONG, OP_SUBTRACT_ONE_LONG:
        base = mem ? `CIU_CY_IDL_M : `CIU_CY_IDL;
      OP_COMPARE_BYTE, OP_COMPARE_WORD:
        base = mem ? `CIU_CY_CMP_M : (af ? `CIU_CY_CMP_A : `CIU_CY_CMP_R);
      OP_COMPARE_LONG:
        base = mem ? `CIU_CY_COMPARE_LONG_M : (af ? `CIU_CY_COMPARE_LONG_I : `CIU_CY_COMPARE_LONG_R);
      OP_UNSIGNED_QUOTIENT_BYTE:
        base = pick(c, mem ? `CIU_CY_DVB_M :
                       (af ? `CIU_CY_DVB_A : `CIU_CY_DVB_R));
      OP_UNSIGNED_QUOTIENT_WORD:
        base = pick(c, mem ? `CIU_CY_DVW_M : `CIU_CY_DVW_R);
      OP_UNSIGNED_PRODUCT_BYTE:
        base = pick(c, mem ? `CIU_CY_MLB_M :
                       (af ? `CIU_CY_MLB_A : `CIU_CY_MLB_R));
      default:
        base = pick(c, mem ? `CIU_CY_MLW_M :
                       (af ? `CIU_CY_MLW_A : `CIU_CY_MLW_R));
    endcase
    cyc_fn = mem ? base + {1'b0, a} : base;
  endfunction

  assign new_op   = ciu_op_t'(I_PWDATA[`CIU_CTRL_OP_HI:`CIU_CTRL_OP_LO]);
  assign new_form = ciu_form_t'(I_PWDATA[`CIU_CTRL_FM_HI:`CIU_CTRL_FM_LO]);
  assign busy     = (state == ST_RUN);
  assign access   = I_PSEL && I_PENABLE;
  // A write lands only at the edge that completes the access without error
  assign wr_ok    = access && O_PREADY && I_PWRITE && !O_PSLVERR;
  assign start    = wr_ok && (I_PADDR == `CIU_OFF_CTRL) &&
                    I_PWDATA[`CIU_CTRL_START];

  ciu_muldiv u_muldiv (
    .i_op   (new_op),
    .i_form (new_form),
    .i_acc  (acc),
    .i_opnd (opnd),
    .o_acc  (md_acc),
    .o_opnd (md_opnd),
    .o_case (md_case)
  );

  // Result, flags and duration of the operation being started
  always_comb begin
    next_acc   = acc;
    next_opnd  = opnd;
    next_flags = flags;
    next_cyc   = cyc_fn(new_op, new_form, md_case, adj);
    case (new_op)
      OP_ADD_ONE_BYTE, OP_SUBTRACT_ONE_BYTE, OP_ADD_ONE_WORD,
      OP_SUBTRACT_ONE_WORD, OP_ADD_ONE_LONG, OP_SUBTRACT_ONE_LONG:
        {next_flags, next_opnd} = step_fn(new_op, opnd, flags);
      OP_COMPARE_BYTE, OP_COMPARE_WORD: begin
        if (new_form == FORM_ACC) begin
          next_flags = cmp_fn(width_of(new_op), acc >> `CIU_SH_WORD,
                              acc & 32'h0000_FFFF);
        end else begin
          next_flags = cmp_fn(width_of(new_op), acc, opnd);
        end
      end
      OP_COMPARE_LONG:
        next_flags = cmp_fn(W_LONG, acc, opnd);
      OP_UNSIGNED_QUOTIENT_BYTE, OP_UNSIGNED_QUOTIENT_WORD: begin
        next_acc  = md_acc;
        next_opnd = md_opnd;
        next_flags[`CIU_FLAG_V] = (md_case == CASE_OVF);
        next_flags[`CIU_FLAG_C] = (md_case == CASE_OVF);
      end
      default: next_acc = md_acc;
    endcase
  end

  ciu_timer u_timer (
    .i_clk   (I_SYS_CLK),
    .i_rst_n (rst_n),
    .i_load  (start),
    .i_count (next_cyc),
    .o_last  (tmr_last)
  );

  // Operation sequencing
  always_ff @(posedge I_SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE;
    end else begin
      case (state)
        ST_IDLE: if (start) state <= ST_RUN;
        ST_RUN:  if (tmr_last) state <= ST_IDLE;
        default: state <= ST_IDLE;
      endcase
    end
  end

  // Latched operation and pending results
  always_ff @(posedge I_SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      op         <= OP_ADD_ONE_BYTE;
      form       <= FORM_ACC;
      cyc        <= `CIU_RST_CYC;
      pend_acc   <= `CIU_RST_WORD;
      pend_opnd  <= `CIU_RST_WORD;
      pend_flags <= `CIU_RST_FLAGS;
    end else if (start) begin
      op         <= new_op;
      form       <= new_form;
      cyc        <= next_cyc;
      pend_acc   <= next_acc;
      pend_opnd  <= next_opnd;
      pend_flags <= next_flags;
    end
  end

  // Accumulator, operand and flags: software writes or operation results
  always_ff @(posedge I_SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      acc   <= `CIU_RST_WORD;
      opnd  <= `CIU_RST_WORD;
      flags <= `CIU_RST_FLAGS;
    end else if (busy && tmr_last) begin
      acc   <= pend_acc;
      opnd  <= pend_opnd;
      flags <= pend_flags;
    end else if (wr_ok) begin
      if (I_PADDR == `CIU_OFF_ACC)   acc   <= I_PWDATA;
      if (I_PADDR == `CIU_OFF_OPND)  opnd  <= I_PWDATA;
      if (I_PADDR == `CIU_OFF_FLAGS) flags <= I_PWDATA[3:0];
    end
  end

  // Addressing correction added to memory forms
  always_ff @(posedge I_SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      adj <= `CIU_RST_ADJ;
    end else if (wr_ok && I_PADDR == `CIU_OFF_ADJ) begin
      adj <= I_PWDATA[7:0];
    end
  end

  // Memory-form step holds the bus from read to write back
  always_ff @(posedge I_SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      O_BUS_LOCK <= 1'b0;
    end else if (start) begin
      O_BUS_LOCK <= (new_form == FORM_MEM) &&
                    (width_of(new_op) != W_LONG ||
                     new_op == OP_ADD_ONE_LONG ||
                     new_op == OP_SUBTRACT_ONE_LONG) &&
                    (new_op < OP_COMPARE_BYTE);
    end else if (busy && tmr_last) begin
      O_BUS_LOCK <= 1'b0;
    end
  end

  // Status outputs track the state at the same edge from flops, except flags lag a software write by one edge
  always_ff @(posedge I_SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      O_BUSY  <= 1'b0;
      O_FLAGS <= `CIU_RST_FLAGS;
    end else begin
      O_BUSY  <= start || (busy && !tmr_last);
      O_FLAGS <= (busy && tmr_last) ? pend_flags : flags;
    end
  end

  // Read data and error for the access being answered
  always_comb begin
    next_rdata = 32'h0000_0000;
    next_err   = 1'b0;
    case (I_PADDR)
      `CIU_OFF_CTRL: begin
        next_rdata[`CIU_CTRL_OP_HI:`CIU_CTRL_OP_LO] = op;
        next_rdata[`CIU_CTRL_FM_HI:`CIU_CTRL_FM_LO] = form;
        next_err = I_PWRITE && (busy || (I_PWDATA[`CIU_CTRL_START] &&
                   (new_op > `CIU_OP_LAST || new_form == FORM_RSV)));
      end
      `CIU_OFF_STAT: begin
        next_rdata[`CIU_STAT_BUSY] = busy;
        next_rdata[`CIU_STAT_LOCK] = O_BUS_LOCK;
        next_err = I_PWRITE;
      end
      `CIU_OFF_ACC: begin
        next_rdata = acc;
        next_err   = I_PWRITE && busy;
      end
      `CIU_OFF_OPND: begin
        next_rdata = opnd;
        next_err   = I_PWRITE && busy;
      end
      `CIU_OFF_FLAGS: begin
        next_rdata[3:0] = flags;
        next_err        = I_PWRITE && busy;
      end
      `CIU_OFF_ADJ: begin
        next_rdata[7:0] = adj;
        next_err        = I_PWRITE && busy;
      end
      `CIU_OFF_CYC: begin
        next_rdata[8:0] = cyc;
        next_err        = I_PWRITE;
      end
      default: next_err = 1'b1;
    endcase
  end

  // One wait state: answer in the second access cycle
  always_ff @(posedge I_SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      O_PREADY  <= 1'b0;
      O_PRDATA  <= `CIU_RST_WORD;
      O_PSLVERR <= 1'b0;
    end else begin
      O_PREADY <= access && !O_PREADY;
      if (access && !O_PREADY) begin
        O_PRDATA  <= I_PWRITE ? `CIU_RST_WORD : next_rdata;
        O_PSLVERR <= next_err;
      end else begin
        O_PSLVERR <= 1'b0;
      end
    end
  end
endmodule

// ==== tb/ciu_top_asserts.sv ====
// Port-level checks of the arithmetic unit
`timescale 1ns/1ps
`include "ciu_cfg.svh"
module ciu_top_asserts (
  // Clock and reset
  input wire logic        I_SYS_CLK,
  input wire logic        I_RSTN,
  // APB
  input wire logic        I_PSEL,
  input wire logic        I_PENABLE,
  input wire logic        I_PWRITE,
  input wire logic [7:0]  I_PADDR,
  input wire logic [31:0] I_PWDATA,
  input wire logic [31:0] O_PRDATA,
  input wire logic        O_PREADY,
  input wire logic        O_PSLVERR,
  // Status
  input wire logic        O_BUSY,
  input wire logic        O_BUS_LOCK,
  input wire logic [3:0]  O_FLAGS
);
  default clocking cb @(posedge I_SYS_CLK); endclocking
  default disable iff (!I_RSTN);
  logic       start;
  logic       acc1;
  logic [5:0] code;
  // Accepted start write with its form and operation code
  assign start = I_PSEL && I_PENABLE && O_PREADY && !O_PSLVERR && I_PWRITE
                 && I_PADDR == `CIU_OFF_CTRL && I_PWDATA[`CIU_CTRL_START];
  assign acc1 = I_PSEL && I_PENABLE && !O_PREADY;
  assign code = I_PWDATA[5:0];
  sequence s_go(logic [5:0] c);
    start && code == c;
  endsequence
  sequence s_setup;
    I_PSEL && !I_PENABLE;
  endsequence
  property p_incb; s_go(6'h10) |=> O_BUSY[*2] ##1 !O_BUSY; endproperty
  property p_add_one_word; s_go(6'h12) |=> O_BUSY[*3] ##1 !O_BUSY; endproperty
  property p_add_one_long; s_go(6'h14) |=> O_BUSY[*7] ##1 !O_BUSY; endproperty
  property p_subtract_one_long; s_go(6'h15) |=> O_BUSY[*7] ##1 !O_BUSY; endproperty
  property p_mulflg;
    start && (code[3:0] == 4'hB || code[3:0] == 4'hC)
      |=> $stable(O_FLAGS)[*8];
  endproperty
  property p_lock;
    start && code[5:4] == 2'h2 && code[3:0] <= 4'h5 |=> O_BUS_LOCK;
  endproperty
  property p_lockrise; $rose(O_BUS_LOCK) |-> $past(start); endproperty
  property p_ready; s_setup |=> !O_PREADY ##1 O_PREADY; endproperty
  property p_unmap;
    acc1 && I_PADDR > `CIU_OFF_CYC |=> O_PSLVERR && O_PRDATA == 32'h0;
  endproperty
  property p_busyerr;
    acc1 && I_PWRITE && I_PADDR == `CIU_OFF_ACC |=> !O_BUSY || O_PSLVERR;
  endproperty
  a_incb: assert property (p_incb) else $error("byte add-one length");
  a_add_one_word: assert property (p_add_one_word) else $error("word add-one length");
  a_add_one_long: assert property (p_add_one_long) else $error("long add-one length");
  a_subtract_one_long: assert property (p_subtract_one_long) else $error("long sub-one length");
  a_mulflg: assert property (p_mulflg) else $error("flags moved");
  a_lock: assert property (p_lock) else $error("lock missing");
  a_lockrise: assert property (p_lockrise) else $error("stray lock");
  a_ready: assert property (p_ready) else $error("ready timing");
  a_unmap: assert property (p_unmap) else $error("unmapped accepted");
  a_busyerr: assert property (p_busyerr) else $error("write while busy");
endmodule

// ==== tb/tb_top.sv ====
// Self-checking bench for the arithmetic unit over APB
`timescale 1ns/1ps
`include "ciu_cfg.svh"
module tb_top;
  logic        clk;
  logic        rstn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        busy;
  logic        lock;
  logic [3:0]  flags;
  logic [31:0] rd;
  logic        err;
  int          miscompares;
  int          total_checks;
  int          cycles;

  ciu_top DUT (
    .I_SYS_CLK(clk), .I_RSTN(rstn), .I_PSEL(psel), .I_PENABLE(penable),
    .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata),
    .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr),
    .O_BUSY(busy), .O_BUS_LOCK(lock), .O_FLAGS(flags)
  );

  always #2.5 clk = ~clk;

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 4000) begin
      miscompares++;
      wrap_up;
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask

  // One APB transfer; read data and error taken at the ready edge
  task automatic xfer(input logic wr, input logic [7:0] a,
                      input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Busy is already up at the edge after the start edge
  task automatic wait_idle;
    do begin
      @(posedge clk);
    end while (busy !== 1'b0);
  endtask

  // Load operands and flags, start, then compare results and count
  task automatic run(input logic [5:0] c, input logic [31:0] acc, opnd,
                     input logic [3:0] f, input logic [31:0] eacc, eopnd,
                     input logic [3:0] ef, input logic [8:0] ecyc);
    xfer(1'b1, `CIU_OFF_ACC, acc);
    xfer(1'b1, `CIU_OFF_OPND, opnd);
    xfer(1'b1, `CIU_OFF_FLAGS, {28'h0, f});
    xfer(1'b1, `CIU_OFF_CTRL, {23'h0, 1'b1, 2'h0, c});
    chk(err, 32'h0);
    wait_idle;
    xfer(1'b0, `CIU_OFF_ACC, 32'h0);
    chk(rd, eacc);
    xfer(1'b0, `CIU_OFF_OPND, 32'h0);
    chk(rd, eopnd);
    xfer(1'b0, `CIU_OFF_FLAGS, 32'h0);
    chk(rd, {28'h0, ef});
    chk(flags, ef);
    xfer(1'b0, `CIU_OFF_CYC, 32'h0);
    chk(rd, {23'h0, ecyc});
  endtask

  initial begin
    clk = 1'b0;
    rstn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h0;
    pwdata = 32'h0;
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    xfer(1'b0, `CIU_OFF_FLAGS, 32'h0);
    chk(rd, 32'h0);
    xfer(1'b0, `CIU_OFF_CYC, 32'h0);
    chk(rd, 32'h0);
    xfer(1'b0, 8'h1C, 32'h0);
    chk({rd[30:0], err}, 32'h1);
    xfer(1'b1, `CIU_OFF_STAT, 32'h1);
    chk(err, 32'h1);
    xfer(1'b1, `CIU_OFF_CTRL, 32'h10D);
    chk(err, 32'h1);
    xfer(1'b1, `CIU_OFF_CTRL, 32'h130);
    chk(err, 32'h1);
    run(6'h10, 32'h0, 32'h1234_567F, 4'h1,
        32'h0, 32'h1234_5680, 4'hB, 9'h2);
    run(6'h11, 32'h0, 32'h1, 4'h0, 32'h0, 32'h0, 4'h4, 9'h3);
    run(6'h12, 32'h0, 32'hAAAA_FFFF, 4'h0,
        32'h0, 32'hAAAA_0000, 4'h4, 9'h3);
    run(6'h13, 32'h0, 32'h8000, 4'h1, 32'h0, 32'h7FFF, 4'h3, 9'h3);
    run(6'h14, 32'h0, 32'hFFFF_FFFF, 4'h0,
        32'h0, 32'h0, 4'h4, 9'h7);
    run(6'h15, 32'h0, 32'h0, 4'h1,
        32'h0, 32'hFFFF_FFFF, 4'h9, 9'h7);
    run(6'h06, 32'h1_0002, 32'h0, 4'h0,
        32'h1_0002, 32'h0, 4'h9, 9'h1);
    run(6'h17, 32'h8000, 32'h1, 4'h0, 32'h8000, 32'h1, 4'h2, 9'h2);
    run(6'h08, 32'h5, 32'h5, 4'h0, 32'h5, 32'h5, 4'h4, 9'h3);
    run(6'h09, 32'h64_0007, 32'h0, 4'hF,
        32'h2_000E, 32'h0, 4'hC, 9'h00F);
    run(6'h09, 32'h5_0000, 32'h0, 4'h0,
        32'h5_0000, 32'h0, 4'h3, 9'h7);
    run(6'h09, 32'h3_0007, 32'h0, 4'h0,
        32'h3_0000, 32'h0, 4'h0, 9'h3);
    run(6'h19, 32'h200, 32'h2, 4'h0,
        32'h200, 32'h2, 4'h3, 9'h8);
    run(6'h1A, 32'h64, 32'h7, 4'hF,
        32'hE, 32'h2, 4'hC, 9'h016);
    run(6'h0B, 32'h0, 32'h0, 4'hA, 32'h0, 32'h0, 4'hA, 9'h3);
    run(6'h0C, 32'h3_0005, 32'h0, 4'hA,
        32'hF, 32'h0, 4'hA, 9'h00B);
    run(6'h1B, 32'h10, 32'h10, 4'hA,
        32'h100, 32'h10, 4'hA, 9'h8);
    run(6'h1C, 32'h0, 32'h0, 4'hA, 32'h0, 32'h0, 4'hA, 9'h4);
    xfer(1'b1, `CIU_OFF_ADJ, 32'h2);
    run(6'h20, 32'h0, 32'hFF, 4'h1, 32'h0, 32'h0, 4'h5, 9'h7);
    run(6'h25, 32'h0, 32'h8000_0000, 4'h0,
        32'h0, 32'h7FFF_FFFF, 4'h2, 9'h00B);
    xfer(1'b1, `CIU_OFF_CTRL, 32'h124);
    xfer(1'b1, `CIU_OFF_ACC, 32'h55);
    chk(err, 32'h1);
    xfer(1'b0, `CIU_OFF_STAT, 32'h0);
    chk(rd, 32'h3);
    chk(lock, 1'b1);
    wait_idle;
    chk(lock, 1'b0);
    xfer(1'b0, `CIU_OFF_ACC, 32'h0);
    chk(rd, 32'h0);
    wrap_up;
  end
endmodule

bind ciu_top ciu_top_asserts u_chk (
  .I_SYS_CLK(I_SYS_CLK), .I_RSTN(I_RSTN), .I_PSEL(I_PSEL),
  .I_PENABLE(I_PENABLE), .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR),
  .I_PWDATA(I_PWDATA), .O_PRDATA(O_PRDATA), .O_PREADY(O_PREADY),
  .O_PSLVERR(O_PSLVERR), .O_BUSY(O_BUSY), .O_BUS_LOCK(O_BUS_LOCK),
  .O_FLAGS(O_FLAGS)
);
